// file: inc/dtu_pkg.sv
package dtu_pkg;

  localparam int WORD_W = 16;
  localparam int ADDR_W = 12;
  localparam int DEPTH  = 4096;
  localparam int SIZE_W = 11;
  localparam int CNT_W  = 10;
  localparam int STEP_W = 16;

  localparam logic [SIZE_W-1:0] TABLE_MIN = 11'h001;
  localparam logic [SIZE_W-1:0] TABLE_MAX = 11'h400;

  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [STEP_W-1:0] STEP_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
  localparam logic [CNT_W-1:0]  CNT_RST  = 10'h000;

  typedef enum logic [2:0] {
    end_op,
    word_copy_op,
    double_word_copy_op,
    invert_copy_op,
    word_swap_op,
    table_fill_op,
    table_block_copy_op
  } op_t;

  typedef enum logic {
    st_idle,
    st_exec
  } state_t;

endpackage

// file: inc/rf_if.sv
`timescale 1ns/1ps
interface rf_if;
  import dtu_pkg::*;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [WORD_W-1:0] wr_data;
  logic [ADDR_W-1:0] ra_addr;
  logic [WORD_W-1:0] ra_data;
  logic [ADDR_W-1:0] rb_addr;
  logic [WORD_W-1:0] rb_data;
  logic [ADDR_W-1:0] rc_addr;
  logic [WORD_W-1:0] rc_data;

  modport ctrl (output wr_en, wr_addr, wr_data, ra_addr, rb_addr, rc_addr,
                input  ra_data, rb_data, rc_data);
  modport mem  (input  wr_en, wr_addr, wr_data, ra_addr, rb_addr, rc_addr,
                output ra_data, rb_data, rc_data);
endinterface

// file: logic/word_regfile.sv
`timescale 1ns/1ps
module word_regfile
  import dtu_pkg::*;
(
  input  wire logic ref_clk,
  rf_if.mem         rf
);

  // data memory holds no reset; only control state needs one
  logic [WORD_W-1:0] mem [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (rf.wr_en) begin
      mem[rf.wr_addr] <= rf.wr_data;
    end
  end

  assign rf.ra_data = mem[rf.ra_addr];
  assign rf.rb_data = mem[rf.rb_addr];
  assign rf.rc_data = mem[rf.rc_addr];

endmodule

// file: logic/data_transfer_instr_unit.sv
`timescale 1ns/1ps
module data_transfer_instr_unit
  import dtu_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              scan_start,
  input  wire logic              instr_valid,
  output logic                   instr_ready,
  input  wire op_t               instr_op,
  input  wire logic              rung_in,
  input  wire logic [ADDR_W-1:0] src_base,
  input  wire logic              src_indexed,
  input  wire logic              src_is_const,
  input  wire logic [WORD_W-1:0] src_const,
  input  wire logic [ADDR_W-1:0] dst_base,
  input  wire logic              dst_indexed,
  input  wire logic [SIZE_W-1:0] table_size,
  input  wire logic [WORD_W-1:0] index_value,
  output logic                   done,
  output logic                   rung_out,
  output logic                   size_err,
  output logic                   end_reached,
  output logic [STEP_W-1:0]      used_steps,
  input  wire logic [ADDR_W-1:0] peek_addr,
  output logic [WORD_W-1:0]      peek_data
);

  rf_if rf ();

  word_regfile u_regfile (
    .ref_clk (ref_clk),
    .rf      (rf.mem)
  );

  state_t            state_q,   state_d;
  op_t               op_q,      op_d;
  logic [ADDR_W-1:0] src_q,     src_d;
  logic [ADDR_W-1:0] dst_q,     dst_d;
  logic [WORD_W-1:0] tmp_a_q,   tmp_a_d;
  logic [WORD_W-1:0] tmp_b_q,   tmp_b_d;
  logic [CNT_W-1:0]  step_q,    step_d;
  logic [CNT_W-1:0]  last_q,    last_d;
  logic              down_q,    down_d;
  logic              done_q,    done_d;
  logic              rung_q,    rung_d;
  logic              err_q,     err_d;
  logic              ended_q,   ended_d;
  logic [STEP_W-1:0] steps_q,   steps_d;
  logic [WORD_W-1:0] peek_q;

  logic              accept;
  logic              is_table;
  logic              size_ok;
  logic [ADDR_W-1:0] src_eff;
  logic [ADDR_W-1:0] dst_eff;
  logic [WORD_W-1:0] src_val;
  logic [CNT_W-1:0]  size_last;
  logic [CNT_W-1:0]  offset;
  logic              ended_base;
  logic [STEP_W-1:0] steps_base;

  assign instr_ready = (state_q == st_idle);
  assign accept      = instr_valid && instr_ready;
  assign is_table    = (instr_op == table_fill_op) || (instr_op == table_block_copy_op);
  assign size_ok     = (table_size >= TABLE_MIN) && (table_size <= TABLE_MAX);
  assign size_last   = CNT_W'(table_size - TABLE_MIN);
  assign src_eff     = src_base + (src_indexed ? index_value[ADDR_W-1:0] : ADDR_RST);
  assign dst_eff     = dst_base + (dst_indexed ? index_value[ADDR_W-1:0] : ADDR_RST);
  assign src_val     = src_is_const ? src_const : rf.ra_data;
  assign offset      = down_q ? CNT_W'(last_q - step_q) : step_q;
  assign ended_base  = scan_start ? 1'b0 : ended_q;
  assign steps_base  = scan_start ? STEP_RST : steps_q;

  assign rf.rc_addr  = peek_addr;

  always_comb begin
    state_d    = state_q;
    op_d       = op_q;
    src_d      = src_q;
    dst_d      = dst_q;
    tmp_a_d    = tmp_a_q;
    tmp_b_d    = tmp_b_q;
    step_d     = step_q;
    last_d     = last_q;
    down_d     = down_q;
    done_d     = 1'b0;
    rung_d     = rung_q;
    err_d      = err_q;
    ended_d    = ended_base;
    steps_d    = steps_base;
    rf.wr_en   = 1'b0;
    rf.wr_addr = dst_q;
    rf.wr_data = tmp_a_q;
    // idle reads feed the operand latches; exec reads walk the source table
    rf.ra_addr = (state_q == st_idle) ? src_eff : src_q + ADDR_W'(offset);
    rf.rb_addr = (instr_op == word_swap_op) ? dst_eff : src_eff + ADDR_W'(1);
    case (state_q)
      st_idle: begin
        if (accept) begin
          steps_d = steps_base + STEP_W'(1);
          if (ended_base || instr_op == end_op) begin
            ended_d = 1'b1;
            done_d  = 1'b1;
            rung_d  = 1'b0;
          end else if (!rung_in) begin
            done_d = 1'b1;
            rung_d = 1'b0;
          end else if (is_table && !size_ok) begin
            done_d = 1'b1;
            rung_d = 1'b0;
            err_d  = 1'b1;
          end else begin
            err_d   = 1'b0;
            op_d    = instr_op;
            src_d   = src_eff;
            dst_d   = dst_eff;
            tmp_a_d = src_val;
            tmp_b_d = rf.rb_data;
            step_d  = CNT_RST;
            down_d  = 1'b0;
            state_d = st_exec;
            case (instr_op)
              double_word_copy_op, word_swap_op: last_d = CNT_W'(1);
              table_fill_op:                     last_d = size_last;
              table_block_copy_op: begin
                last_d = size_last;
                // copy from the top when the destination sits above the source
                down_d = (dst_eff > src_eff);
              end
              default: last_d = CNT_RST;
            endcase
          end
        end
      end
      st_exec: begin
        rf.wr_en = 1'b1;
        case (op_q)
          word_copy_op:   rf.wr_data = tmp_a_q;
          double_word_copy_op: begin
            rf.wr_addr = dst_q + ADDR_W'(step_q);
            rf.wr_data = step_q[0] ? tmp_b_q : tmp_a_q;
          end
          invert_copy_op: rf.wr_data = ~tmp_a_q;
          word_swap_op: begin
            rf.wr_addr = step_q[0] ? dst_q : src_q;
            rf.wr_data = step_q[0] ? tmp_a_q : tmp_b_q;
          end
          table_fill_op: begin
            rf.wr_addr = dst_q + ADDR_W'(step_q);
            rf.wr_data = tmp_a_q;
          end
          table_block_copy_op: begin
            rf.wr_addr = dst_q + ADDR_W'(offset);
            rf.wr_data = rf.ra_data;
          end
          default: rf.wr_en = 1'b0;
        endcase
        if (step_q == last_q) begin
          done_d  = 1'b1;
          rung_d  = 1'b1;
          state_d = st_idle;
        end else begin
          step_d = step_q + CNT_W'(1);
        end
      end
      default: state_d = st_idle;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= st_idle;
      op_q    <= end_op;
      src_q   <= ADDR_RST;
      dst_q   <= ADDR_RST;
      tmp_a_q <= WORD_RST;
      tmp_b_q <= WORD_RST;
      step_q  <= CNT_RST;
      last_q  <= CNT_RST;
      down_q  <= 1'b0;
      done_q  <= 1'b0;
      rung_q  <= 1'b0;
      err_q   <= 1'b0;
      ended_q <= 1'b0;
      steps_q <= STEP_RST;
      peek_q  <= WORD_RST;
    end else begin
      state_q <= state_d;
      op_q    <= op_d;
      src_q   <= src_d;
      dst_q   <= dst_d;
      tmp_a_q <= tmp_a_d;
      tmp_b_q <= tmp_b_d;
      step_q  <= step_d;
      last_q  <= last_d;
      down_q  <= down_d;
      done_q  <= done_d;
      rung_q  <= rung_d;
      err_q   <= err_d;
      ended_q <= ended_d;
      steps_q <= steps_d;
      peek_q  <= rf.rc_data;
    end
  end

  assign done        = done_q;
  assign rung_out    = rung_q;
  assign size_err    = err_q;
  assign end_reached = ended_q;
  assign used_steps  = steps_q;
  assign peek_data   = peek_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  logic run_ok;
  assign run_ok = accept && rung_in && !ended_base && instr_op != end_op;

  property p_rung_off;
    accept && !rung_in |=> done && !rung_out && !rf.wr_en;
  endproperty
  a_rung_off: assert property (p_rung_off) else $error("rung off still executed");

  property p_after_end;
    accept && ended_q && !scan_start |=> done && !rung_out && !rf.wr_en;
  endproperty
  a_after_end: assert property (p_after_end) else $error("instruction ran after terminator");

  property p_multi_end;
    accept && ended_q && !scan_start && instr_op == end_op
      |=> end_reached && done && size_err == $past(size_err);
  endproperty
  a_multi_end: assert property (p_multi_end) else $error("second terminator mishandled");

  property p_steps;
    accept && !scan_start |=> used_steps == $past(used_steps) + 16'h0001;
  endproperty
  a_steps: assert property (p_steps) else $error("used step count not advanced");

  property p_word_copy;
    run_ok && instr_op == word_copy_op
      |=> rf.wr_en && rf.wr_data == $past(src_val) && rf.wr_addr == $past(dst_eff) ##1 done && rung_out;
  endproperty
  a_word_copy: assert property (p_word_copy) else $error("word copy wrong");

  property p_index;
    instr_ready && src_indexed |-> rf.ra_addr == ADDR_W'(src_base + index_value[ADDR_W-1:0]);
  endproperty
  a_index: assert property (p_index) else $error("indexed address wrong");

  property p_dword;
    run_ok && instr_op == double_word_copy_op
      |=> rf.wr_addr == $past(dst_eff) && rf.wr_data == $past(src_val)
      ##1 rf.wr_addr == $past(dst_eff, 2) + ADDR_W'(1) && rf.wr_data == $past(rf.rb_data, 2);
  endproperty
  a_dword: assert property (p_dword) else $error("double word halves misplaced");

  property p_invert;
    run_ok && instr_op == invert_copy_op |=> rf.wr_en && rf.wr_data == ~$past(src_val);
  endproperty
  a_invert: assert property (p_invert) else $error("invert copy wrong");

  property p_swap;
    run_ok && instr_op == word_swap_op
      |=> rf.wr_data == $past(rf.rb_data) ##1 rf.wr_data == $past(src_val, 2) && rf.wr_addr == $past(dst_eff, 2);
  endproperty
  a_swap: assert property (p_swap) else $error("swap did not exchange");

  property p_fill4;
    run_ok && instr_op == table_fill_op && table_size == 11'h004 |=> (rf.wr_en && !done) [*4] ##1 done && rung_out;
  endproperty
  a_fill4: assert property (p_fill4) else $error("fill length or completion wrong");

  property p_block_down;
    run_ok && instr_op == table_block_copy_op && size_ok && dst_eff > src_eff
      |=> rf.wr_addr == $past(dst_eff) + ADDR_W'($past(size_last));
  endproperty
  a_block_down: assert property (p_block_down) else $error("overlap copy wrong direction");

  c_block:  cover property (run_ok && instr_op == table_block_copy_op ##[1:1000] done);
  c_dword:  cover property (run_ok && instr_op == double_word_copy_op ##3 done);
  c_ended:  cover property (accept && ended_q && instr_op == end_op);
  c_szerr:  cover property (accept && rung_in && is_table && !size_ok);

endmodule

// file: verification/data_transfer_instr_unit_tb_top.sv
`timescale 1ns/1ps
module data_transfer_instr_unit_tb_top;
  import dtu_pkg::*;
  logic              ref_clk      = 1'b0;
  logic              srst         = 1'b1;
  logic              scan_start   = 1'b0;
  logic              instr_valid  = 1'b0;
  logic              instr_ready;
  op_t               instr_op     = end_op;
  logic              rung_in      = 1'b0;
  logic [ADDR_W-1:0] src_base     = 12'h000;
  logic              src_indexed  = 1'b0;
  logic              src_is_const = 1'b0;
  logic [WORD_W-1:0] src_const    = 16'h0000;
  logic [ADDR_W-1:0] dst_base     = 12'h000;
  logic              dst_indexed  = 1'b0;
  logic [SIZE_W-1:0] table_size   = 11'h000;
  logic [WORD_W-1:0] index_value  = 16'h0000;
  logic              done;
  logic              rung_out;
  logic              size_err;
  logic              end_reached;
  logic [STEP_W-1:0] used_steps;
  logic [ADDR_W-1:0] peek_addr    = 12'h000;
  logic [WORD_W-1:0] peek_data;
  int                miscompares  = 0;
  int                tests_run    = 0;

  always #5 ref_clk = ~ref_clk;

  data_transfer_instr_unit u_dut (
    .ref_clk      (ref_clk),
    .srst         (srst),
    .scan_start   (scan_start),
    .instr_valid  (instr_valid),
    .instr_ready  (instr_ready),
    .instr_op     (instr_op),
    .rung_in      (rung_in),
    .src_base     (src_base),
    .src_indexed  (src_indexed),
    .src_is_const (src_is_const),
    .src_const    (src_const),
    .dst_base     (dst_base),
    .dst_indexed  (dst_indexed),
    .table_size   (table_size),
    .index_value  (index_value),
    .done         (done),
    .rung_out     (rung_out),
    .size_err     (size_err),
    .end_reached  (end_reached),
    .used_steps   (used_steps),
    .peek_addr    (peek_addr),
    .peek_data    (peek_data)
  );

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one instruction, waits for done; latency counted from the take edge
  task automatic iss(input op_t op, input logic r, input logic [ADDR_W-1:0] s, input logic sc,
                     input logic [WORD_W-1:0] cv, input logic [ADDR_W-1:0] d,
                     input logic [SIZE_W-1:0] n, input int lat, input logic ro);
    int k;
    @(posedge ref_clk);
    instr_op <= op;
    rung_in <= r;
    src_base <= s;
    src_is_const <= sc;
    src_const <= cv;
    dst_base <= d;
    table_size <= n;
    instr_valid <= 1'b1;
    #1 chk("instr_ready", instr_ready, 1'b1);
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    // a refused instruction pulses done right after the take edge, so look before the next edge
    for (k = 1; k <= 1100; k++) begin
      #1;
      if (done === 1'b1) break;
      @(posedge ref_clk);
    end
    if (k > 1100) begin
      miscompares++;
      $display("[FAIL] done expected 1 seen timeout");
      stop_test();
    end
    chk("latency", k, lat);
    chk("rung_out", rung_out, ro);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] v);
    iss(word_copy_op, 1'b1, 12'h000, 1'b1, v, a, 11'h000, 2, 1'b1);
  endtask

  task automatic pk(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] v);
    @(posedge ref_clk);
    peek_addr <= a;
    @(posedge ref_clk);
    @(posedge ref_clk);
    #1 chk("peek_data", peek_data, v);
  endtask

  task automatic scan;
    @(posedge ref_clk);
    scan_start <= 1'b1;
    @(posedge ref_clk);
    scan_start <= 1'b0;
    #1 chk("used_steps", used_steps, 16'h0000);
    chk("end_reached", end_reached, 1'b0);
  endtask

  task automatic t_words;
    wr(12'h500, 16'h5678);
    wr(12'h501, 16'h8012);
    iss(double_word_copy_op, 1'b1, 12'h500, 1'b0, 16'h0000, 12'h510, 11'h000, 3, 1'b1);
    pk(12'h510, 16'h5678);
    pk(12'h511, 16'h8012);
    iss(word_swap_op, 1'b1, 12'h501, 1'b0, 16'h0000, 12'h500, 11'h000, 3, 1'b1);
    pk(12'h500, 16'h8012);
    pk(12'h501, 16'h5678);
    iss(invert_copy_op, 1'b1, 12'h500, 1'b0, 16'h0000, 12'h520, 11'h000, 2, 1'b1);
    iss(invert_copy_op, 1'b1, 12'h000, 1'b1, 16'h4321, 12'h521, 11'h000, 2, 1'b1);
    pk(12'h520, 16'h7fed);
    pk(12'h521, 16'hbcde);
    iss(word_copy_op, 1'b0, 12'h000, 1'b1, 16'hffff, 12'h520, 11'h000, 1, 1'b0);
    pk(12'h520, 16'h7fed);
    wr(12'h110, 16'hbeef);
    @(posedge ref_clk);
    src_indexed <= 1'b1;
    dst_indexed <= 1'b1;
    index_value <= 16'hf010;
    iss(word_copy_op, 1'b1, 12'h100, 1'b0, 16'h0000, 12'h200, 11'h000, 2, 1'b1);
    @(posedge ref_clk);
    src_indexed <= 1'b0;
    dst_indexed <= 1'b0;
    index_value <= 16'h0000;
    pk(12'h210, 16'hbeef);
    $display("test words done");
  endtask

  task automatic t_tables;
    int i;
    wr(12'h2ff, 16'h1111);
    wr(12'h304, 16'h2222);
    iss(table_fill_op, 1'b1, 12'h000, 1'b1, 16'ha5a5, 12'h300, 11'h004, 5, 1'b1);
    pk(12'h2ff, 16'h1111);
    pk(12'h300, 16'ha5a5);
    pk(12'h303, 16'ha5a5);
    pk(12'h304, 16'h2222);
    wr(12'hc00, 16'h3333);
    iss(table_fill_op, 1'b1, 12'h000, 1'b1, 16'h5a5a, 12'h800, 11'h400, 1025, 1'b1);
    pk(12'hbff, 16'h5a5a);
    pk(12'hc00, 16'h3333);
    iss(table_fill_op, 1'b1, 12'h000, 1'b1, 16'h0000, 12'h300, 11'h000, 1, 1'b0);
    chk("size_err", size_err, 1'b1);
    iss(table_block_copy_op, 1'b1, 12'h300, 1'b0, 16'h0000, 12'h800, 11'h401, 1, 1'b0);
    chk("size_err", size_err, 1'b1);
    pk(12'h300, 16'ha5a5);
    for (i = 0; i < 4; i++) wr(12'h400 + i[11:0], 16'h0001 + i[15:0]);
    iss(table_block_copy_op, 1'b1, 12'h400, 1'b0, 16'h0000, 12'h402, 11'h004, 5, 1'b1);
    chk("size_err", size_err, 1'b0);
    for (i = 0; i < 4; i++) pk(12'h402 + i[11:0], 16'h0001 + i[15:0]);
    iss(table_block_copy_op, 1'b1, 12'h402, 1'b0, 16'h0000, 12'h401, 11'h004, 5, 1'b1);
    for (i = 0; i < 4; i++) pk(12'h401 + i[11:0], 16'h0001 + i[15:0]);
    $display("test tables done");
  endtask

  task automatic t_end;
    wr(12'h600, 16'h1111);
    scan();
    // the scan program carries its terminator before any later step
    iss(end_op, 1'b1, 12'h000, 1'b0, 16'h0000, 12'h000, 11'h000, 1, 1'b0);
    iss(end_op, 1'b1, 12'h000, 1'b0, 16'h0000, 12'h000, 11'h000, 1, 1'b0);
    iss(word_copy_op, 1'b1, 12'h000, 1'b1, 16'h2222, 12'h600, 11'h000, 1, 1'b0);
    chk("end_reached", end_reached, 1'b1);
    chk("used_steps", used_steps, 16'h0003);
    pk(12'h600, 16'h1111);
    scan();
    wr(12'h600, 16'h3333);
    chk("used_steps", used_steps, 16'h0001);
    pk(12'h600, 16'h3333);
    $display("test end done");
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    #1 chk("rung_out", rung_out, 1'b0);
    chk("used_steps", used_steps, 16'h0000);
    t_words();
    t_tables();
    t_end();
    stop_test();
  end
endmodule
